// ==== core/obcd_defines.svh ====
// Behaviour
// R1 - Option bytes have no memory-map address; access only in programming mode.
// R2 - Erased or blank storage reads all ones.
// R3 - Byte0 bit7 set: halt entry with running watchdog causes reset.
// R4 - Byte0 bit6 clear: watchdog always on; set: software enables it.
// R5 - Byte0 bit5 clear enables clock guard with filter and backup oscillator.
// R6 - Byte0 bits4:3 pick supply thresholds: 11 off, 10 low, 01 mid, 00 high.
// R7 - Byte0 bit0 clear locks user flash against test and in-circuit access.
// R8 - Erasing option bytes while locked erases all user flash first.
// R9 - Byte1 bit7 set picks large package, clear picks small package.
// R10 - Unbonded pads of each 8-pad port come up input with pull-up.
// R11 - Byte1 bit6 clear gives 4096-cycle delay, set gives 256 cycles.
// R12 - Programmer should pick 4096 cycles when a resonator is used.
// R13 - With clock guard on, delay counting starts at once on backup clock.
// R14 - Flash parts leave factory selecting the internal RC oscillator.
// R15 - Factory-coded ROM parts have fixed, unprogrammable option values.
// R16 - Byte1 bits5:4 pick clock source: resonator, ext RC, int RC, external.
// R17 - Byte1 bits3:1 pick frequency band 1-2, 2-4, 4-8, 8-16 MHz.
// R18 - Byte1 bit0 clear enables doubler, never with internal RC.
// R19 - Programmer enables doubler only with the 2-4 MHz band.
// R20 - Both bytes latch during reset and drive static decoded settings.
`ifndef OBCD_DEFINES_SVH
`define OBCD_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OBCD_ADDR_CTRL 8'h00
`define OBCD_ADDR_OPT0 8'h04
`define OBCD_ADDR_OPT1 8'h08
`define OBCD_ADDR_STAT 8'h0C

// ----------------------------------------
// Fields
// ----------------------------------------
`define OBCD_CTRL_PROG 0
`define OBCD_CTRL_ERASE 1
`define OBCD_B0_HALT 7
`define OBCD_B0_WDG_SOFT 6
`define OBCD_B0_CLKG 5
`define OBCD_B0_SUP_HI 4
`define OBCD_B0_SUP_LO 3
`define OBCD_B0_RDP 0
`define OBCD_B1_PKG 7
`define OBCD_B1_RST_SHORT 6
`define OBCD_B1_OSC_HI 5
`define OBCD_B1_OSC_LO 4
`define OBCD_B1_BAND_HI 3
`define OBCD_B1_BAND_LO 1
`define OBCD_B1_PLL 0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define OBCD_ERASED 8'hFF
`define OBCD_SHIP_B1 8'hEF
`define OBCD_DLY_LONG 13'h1000
`define OBCD_DLY_SHORT 13'h0100
`define OBCD_RESP_OKAY 2'h0
`define OBCD_RESP_SLVERR 2'h2
`define OBCD_RESP_DECERR 2'h3

`endif

// ==== core/obcd_pkg.sv ====
package obcd_pkg;
  typedef enum logic [1:0] {OSC_RESONATOR, OSC_EXT_RC, OSC_INT_RC, OSC_EXT_CLK} obcd_osc_e;
  typedef enum logic [1:0] {SUP_HIGH, SUP_MID, SUP_LOW, SUP_OFF} obcd_sup_e;
  typedef enum {ERS_IDLE, ERS_USER, ERS_OPT} obcd_ers_e;
  typedef enum {DLY_IDLE, DLY_WAIT_OSC, DLY_COUNT} obcd_dly_e;
  typedef enum {REG_CTRL, REG_OPT0, REG_OPT1, REG_STAT, REG_NONE} obcd_reg_e;
endpackage

// ==== core/obcd_top.sv ====
`timescale 1ns/1ns
`include "obcd_defines.svh"
module obcd_top #(
  parameter bit ROM_CODED = 1'b0,
  parameter logic [7:0] ROM_OPT0 = 8'hFF,
  parameter logic [7:0] ROM_OPT1 = 8'hEF,
  parameter logic [31:0] SMALL_PKG_UNBONDED = 32'hF000_F000
)(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // System events
  input wire logic halt_entry,
  input wire logic wdg_running,
  input wire logic halt_exit_req,
  input wire logic main_osc_ready,
  input wire logic flash_erase_done,
  output logic flash_mass_erase,
  output logic halt_wdg_reset,
  output logic halt_exit_done,
  // Decoded configuration
  output logic wdg_hw_enable,
  output logic halt_reset_on_wdg_reset_en,
  output logic clk_guard_en,
  output logic supply_detect_en,
  output logic [1:0] supply_thresh,
  output logic readout_lock,
  output logic pkg_large,
  output logic [31:0] pad_pullup_force,
  output logic [12:0] rst_delay_cycles,
  output logic [1:0] osc_kind,
  output logic [2:0] osc_band,
  output logic pll_en
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic obcd_pkg::obcd_reg_e dec_addr(input logic [7:0] a);
    case (a)
      `OBCD_ADDR_CTRL: dec_addr = obcd_pkg::REG_CTRL;
      `OBCD_ADDR_OPT0: dec_addr = obcd_pkg::REG_OPT0;
      `OBCD_ADDR_OPT1: dec_addr = obcd_pkg::REG_OPT1;
      `OBCD_ADDR_STAT: dec_addr = obcd_pkg::REG_STAT;
      default: dec_addr = obcd_pkg::REG_NONE;
    endcase
  endfunction

  logic [7:0] opt_mem [0:1];
  logic [7:0] eff0;
  logic [7:0] eff1;
  logic [7:0] cfg0_r;
  logic [7:0] cfg1_r;
  logic [7:0] src0;
  logic [7:0] src1;
  logic prog_mode_r;
  obcd_pkg::obcd_ers_e ers_state_r;
  obcd_pkg::obcd_dly_e dly_state_r;
  logic [12:0] dly_cnt_r;
  logic osc_meta_r;
  logic osc_sync_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic wr_fire;
  obcd_pkg::obcd_reg_e wr_idx;
  logic [1:0] wr_resp;
  obcd_pkg::obcd_reg_e rd_idx;

  // ROM parts ignore the stored bytes entirely
  assign eff0 = ROM_CODED ? ROM_OPT0 : opt_mem[0]; // [R15]
  assign eff1 = ROM_CODED ? ROM_OPT1 : opt_mem[1]; // [R15]
  assign src0 = aresetn ? cfg0_r : eff0;
  assign src1 = aresetn ? cfg1_r : eff1;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid;
  assign wr_idx = dec_addr(awaddr_r);
  assign rd_idx = dec_addr(araddr);

  always_comb
  begin
    wr_resp = `OBCD_RESP_OKAY;
    if (wr_idx == obcd_pkg::REG_NONE)
    begin
      wr_resp = `OBCD_RESP_DECERR;
    end
    else if ((wr_idx == obcd_pkg::REG_OPT0 || wr_idx == obcd_pkg::REG_OPT1) && (!prog_mode_r || ROM_CODED))
    begin
      wr_resp = `OBCD_RESP_SLVERR; // [R1] [R15]
    end
  end

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `OBCD_RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_hold_r <= 1'b1;
        wbyte_r <= wdata[7:0];
        wlane_r <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_resp;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `OBCD_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= 32'h0000_0000;
      rresp <= `OBCD_RESP_OKAY;
      case (rd_idx)
        obcd_pkg::REG_CTRL: rdata <= {31'h0000_0000, prog_mode_r};
        obcd_pkg::REG_OPT0, obcd_pkg::REG_OPT1:
        begin
          if (prog_mode_r)
          begin
            rdata <= {24'h00_0000, (rd_idx == obcd_pkg::REG_OPT0) ? eff0 : eff1}; // [R1]
          end
          else
          begin
            rresp <= `OBCD_RESP_SLVERR; // [R1]
          end
        end
        obcd_pkg::REG_STAT:
          rdata <= {28'h000_0000, ROM_CODED, flash_mass_erase, ers_state_r != obcd_pkg::ERS_IDLE, prog_mode_r};
        default: rresp <= `OBCD_RESP_DECERR;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Programming mode and storage
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prog_mode_r <= 1'b0;
    end
    else if (wr_fire && wr_idx == obcd_pkg::REG_CTRL && wlane_r)
    begin
      prog_mode_r <= wbyte_r[`OBCD_CTRL_PROG];
    end
  end

  // Not cleared by system reset: models non-volatile cells
  always_ff @(posedge aclk)
  begin
    if (!por_n)
    begin
      opt_mem[0] <= `OBCD_ERASED; // [R2]
      opt_mem[1] <= `OBCD_SHIP_B1; // [R14]
    end
    else if (ers_state_r == obcd_pkg::ERS_OPT)
    begin
      opt_mem[0] <= `OBCD_ERASED; // [R2] [R8]
      opt_mem[1] <= `OBCD_ERASED; // [R2]
    end
    else if (wr_fire && wr_resp == `OBCD_RESP_OKAY && wlane_r && ers_state_r == obcd_pkg::ERS_IDLE)
    begin
      if (wr_idx == obcd_pkg::REG_OPT0)
      begin
        opt_mem[0] <= wbyte_r; // [R1]
      end
      if (wr_idx == obcd_pkg::REG_OPT1)
      begin
        opt_mem[1] <= wbyte_r; // [R1]
      end
    end
  end

  // ----------------------------------------
  // Erase sequence
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ers_state_r <= obcd_pkg::ERS_IDLE;
      flash_mass_erase <= 1'b0;
    end
    else
    begin
      case (ers_state_r)
        obcd_pkg::ERS_IDLE:
        begin
          if (wr_fire && wr_idx == obcd_pkg::REG_CTRL && wlane_r && wbyte_r[`OBCD_CTRL_ERASE]
              && prog_mode_r && !ROM_CODED)
          begin
            if (!eff0[`OBCD_B0_RDP])
            begin
              ers_state_r <= obcd_pkg::ERS_USER; // [R8]
              flash_mass_erase <= 1'b1; // [R8]
            end
            else
            begin
              ers_state_r <= obcd_pkg::ERS_OPT;
            end
          end
        end
        obcd_pkg::ERS_USER:
        begin
          if (flash_erase_done)
          begin
            flash_mass_erase <= 1'b0;
            ers_state_r <= obcd_pkg::ERS_OPT; // [R8]
          end
        end
        obcd_pkg::ERS_OPT: ers_state_r <= obcd_pkg::ERS_IDLE;
        default: ers_state_r <= obcd_pkg::ERS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Reset-time latch and decode
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg0_r <= eff0; // [R20]
      cfg1_r <= eff1; // [R20]
    end
  end

  // Held static after reset: later programming only takes effect at next reset
  always_ff @(posedge aclk)
  begin
    halt_reset_on_wdg_reset_en <= src0[`OBCD_B0_HALT]; // [R3]
    wdg_hw_enable <= !src0[`OBCD_B0_WDG_SOFT]; // [R4]
    clk_guard_en <= !src0[`OBCD_B0_CLKG]; // [R5]
    supply_thresh <= src0[`OBCD_B0_SUP_HI:`OBCD_B0_SUP_LO]; // [R6]
    supply_detect_en <= src0[`OBCD_B0_SUP_HI:`OBCD_B0_SUP_LO] != obcd_pkg::SUP_OFF; // [R6]
    readout_lock <= !src0[`OBCD_B0_RDP]; // [R7]
    pkg_large <= src1[`OBCD_B1_PKG]; // [R9]
    pad_pullup_force <= src1[`OBCD_B1_PKG] ? 32'h0000_0000 : SMALL_PKG_UNBONDED; // [R10]
    rst_delay_cycles <= src1[`OBCD_B1_RST_SHORT] ? `OBCD_DLY_SHORT : `OBCD_DLY_LONG; // [R11]
    osc_kind <= src1[`OBCD_B1_OSC_HI:`OBCD_B1_OSC_LO]; // [R16]
    osc_band <= src1[`OBCD_B1_BAND_HI:`OBCD_B1_BAND_LO]; // [R17]
    pll_en <= !src1[`OBCD_B1_PLL] && src1[`OBCD_B1_OSC_HI:`OBCD_B1_OSC_LO] != obcd_pkg::OSC_INT_RC; // [R18]
  end

  // ----------------------------------------
  // Halt handling
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_wdg_reset <= 1'b0;
    end
    else
    begin
      halt_wdg_reset <= halt_entry && wdg_running && cfg0_r[`OBCD_B0_HALT]; // [R3]
    end
  end

  always_ff @(posedge aclk)
  begin
    osc_meta_r <= main_osc_ready;
    osc_sync_r <= osc_meta_r;
  end

  // Backup clock lets the count start without the main oscillator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dly_state_r <= obcd_pkg::DLY_IDLE;
      dly_cnt_r <= 13'h0000;
      halt_exit_done <= 1'b0;
    end
    else
    begin
      halt_exit_done <= 1'b0;
      case (dly_state_r)
        obcd_pkg::DLY_IDLE:
        begin
          dly_cnt_r <= 13'h0000;
          if (halt_exit_req)
          begin
            dly_state_r <= clk_guard_en ? obcd_pkg::DLY_COUNT : obcd_pkg::DLY_WAIT_OSC; // [R13]
          end
        end
        obcd_pkg::DLY_WAIT_OSC:
        begin
          if (osc_sync_r)
          begin
            dly_state_r <= obcd_pkg::DLY_COUNT;
          end
        end
        obcd_pkg::DLY_COUNT:
        begin
          dly_cnt_r <= dly_cnt_r + 13'h0001;
          if (dly_cnt_r == rst_delay_cycles - 13'h0001)
          begin
            halt_exit_done <= 1'b1; // [R11]
            dly_state_r <= obcd_pkg::DLY_IDLE;
          end
        end
        default: dly_state_r <= obcd_pkg::DLY_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_OPT_NEEDS_PROG: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    wr_fire && (wr_idx == obcd_pkg::REG_OPT0 || wr_idx == obcd_pkg::REG_OPT1) && !prog_mode_r
    |=> bresp == `OBCD_RESP_SLVERR && bvalid)
    else $error("option write accepted outside programming mode");
  AST_POR_BLANK: assert property (@(posedge aclk) !por_n |=> eff0 == `OBCD_ERASED || ROM_CODED) // [R2]
    else $error("blank storage not all ones");
  AST_HALT_RESET: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    halt_entry && wdg_running |=> halt_wdg_reset == $past(cfg0_r[`OBCD_B0_HALT]))
    else $error("halt reset does not follow option");
  AST_WDG_HW: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    $past(aresetn) |-> wdg_hw_enable == !cfg0_r[`OBCD_B0_WDG_SOFT] && clk_guard_en == !cfg0_r[`OBCD_B0_CLKG])
    else $error("watchdog or clock guard decode wrong");
  AST_SUPPLY: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    $past(aresetn) |-> supply_detect_en == (cfg0_r[4:3] != 2'h3) && readout_lock == !cfg0_r[0])
    else $error("supply or lock decode wrong");
  AST_ERASE_ORDER: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    ers_state_r == obcd_pkg::ERS_USER |=> $stable(opt_mem[0]) && $stable(opt_mem[1]))
    else $error("option bytes erased before user flash");
  AST_DELAY_LEN: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    $past(aresetn) |-> rst_delay_cycles == (cfg1_r[6] ? 13'h0100 : 13'h1000))
    else $error("delay length decode wrong");
  AST_GUARD_START: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    dly_state_r == obcd_pkg::DLY_IDLE && halt_exit_req && clk_guard_en |=> dly_state_r == obcd_pkg::DLY_COUNT)
    else $error("count did not start at once");
  AST_NO_RC_PLL: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    osc_kind == 2'h2 |-> !pll_en)
    else $error("doubler enabled with internal RC");
  COV_ERASE: cover property (@(posedge aclk) disable iff (!aresetn) ers_state_r == obcd_pkg::ERS_USER ##[1:50] ers_state_r == obcd_pkg::ERS_OPT);
  COV_HALT_RST: cover property (@(posedge aclk) disable iff (!aresetn) halt_wdg_reset);
  COV_EXIT: cover property (@(posedge aclk) disable iff (!aresetn) halt_exit_done);

endmodule // obcd_top

// ==== test/obcd_flash_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// User flash erase responder
// ----------------------------------------
module obcd_flash_model #(
  parameter int DELAY = 20
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Erase handshake
  input wire logic mass_erase,
  output logic erase_done
);
  int cnt;
  // Done is a single-cycle pulse, so a design waiting on a level would hang
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !mass_erase)
    begin
      cnt <= 0;
      erase_done <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      erase_done <= (cnt == DELAY);
    end
  end
endmodule // obcd_flash_model

// ==== test/tb_option_byte_config_decoder.sv ====
`timescale 1ns/1ns
`include "obcd_defines.svh"
module tb_option_byte_config_decoder;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk, aresetn, por_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic halt_entry, wdg_running, halt_exit_req, main_osc_ready;
  wire logic flash_erase_done;
  logic awready, wready, bvalid, arready, rvalid, flash_mass_erase, halt_wdg_reset, halt_exit_done;
  logic [1:0] bresp, rresp, supply_thresh, osc_kind;
  logic [31:0] rdata, pad_pullup_force;
  logic wdg_hw_enable, halt_reset_on_wdg_reset_en, clk_guard_en, supply_detect_en, readout_lock, pkg_large, pll_en;
  logic [12:0] rst_delay_cycles;
  logic [2:0] osc_band;
  logic [7:0] b0, b1;
  int mismatches, checked;

  obcd_top obcd_top_i (
    .aclk, .aresetn, .por_n,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .halt_entry, .wdg_running, .halt_exit_req, .main_osc_ready, .flash_erase_done,
    .flash_mass_erase, .halt_wdg_reset, .halt_exit_done,
    .wdg_hw_enable, .halt_reset_on_wdg_reset_en, .clk_guard_en, .supply_detect_en, .supply_thresh, .readout_lock,
    .pkg_large, .pad_pullup_force, .rst_delay_cycles, .osc_kind, .osc_band, .pll_en
  );
  obcd_flash_model obcd_flash_model_i (.aclk, .aresetn, .mass_erase(flash_mass_erase), .erase_done(flash_erase_done));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task print_verdict;
    $display("Checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task timeout;
    mismatches++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict;
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) timeout;
    chk(bresp, er);
  endtask

  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input bit cd);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) timeout;
    chk(rresp, er);
    if (cd) chk(rdata, e);
  endtask

  task rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task load(input logic [7:0] x0, input logic [7:0] x1);
    axw(`OBCD_ADDR_CTRL, 32'h1, `OBCD_RESP_OKAY);
    axw(`OBCD_ADDR_OPT0, {24'h0, x0}, `OBCD_RESP_OKAY);
    axw(`OBCD_ADDR_OPT1, {24'h0, x1}, `OBCD_RESP_OKAY);
    axr(`OBCD_ADDR_OPT0, {24'h0, x0}, `OBCD_RESP_OKAY, 1'b1);
    axr(`OBCD_ADDR_OPT1, {24'h0, x1}, `OBCD_RESP_OKAY, 1'b1);
    rst;
  endtask

  task check_cfg(input logic [7:0] x0, input logic [7:0] x1);
    @(posedge aclk);
    chk(wdg_hw_enable, !x0[6]);
    chk(halt_reset_on_wdg_reset_en, x0[7]);
    chk(clk_guard_en, !x0[5]);
    chk(supply_thresh, x0[4:3]);
    chk(supply_detect_en, x0[4:3] != 2'h3);
    chk(readout_lock, !x0[0]);
    chk(pkg_large, x1[7]);
    chk(pad_pullup_force, x1[7] ? 32'h0 : 32'hF000_F000);
    chk(rst_delay_cycles, x1[6] ? 32'h100 : 32'h1000);
    chk(osc_kind, x1[5:4]);
    chk(osc_band, x1[3:1]);
    chk(pll_en, !x1[0] && x1[5:4] != 2'h2);
  endtask

  task halt_try(input logic run, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    halt_entry <= 1'b1;
    wdg_running <= run;
    @(posedge aclk);
    halt_entry <= 1'b0;
    repeat (3)
    begin
      @(posedge aclk);
      if (halt_wdg_reset === 1'b1) n++;
    end
    chk(n, e);
  endtask

  // Counts edges from the request edge to the one that sees the done pulse
  task exit_try(input logic osc, input int e);
    int n;
    @(posedge aclk);
    main_osc_ready <= osc;
    repeat (3) @(posedge aclk);
    halt_exit_req <= 1'b1;
    @(posedge aclk);
    halt_exit_req <= 1'b0;
    n = 1;
    while (halt_exit_done !== 1'b1 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 5000) timeout;
    chk(n, e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task sc_blank;
    check_cfg(8'hFF, 8'hEF);
    axr(`OBCD_ADDR_OPT0, 32'h0, `OBCD_RESP_SLVERR, 1'b1);
    axw(`OBCD_ADDR_OPT1, 32'h0, `OBCD_RESP_SLVERR);
    axr(8'h40, 32'h0, `OBCD_RESP_DECERR, 1'b0);
    axr(`OBCD_ADDR_CTRL, 32'h0, `OBCD_RESP_OKAY, 1'b1);
    // Guard off: count waits for the synced main oscillator first
    exit_try(1'b1, 256 + 3);
    rst;
    check_cfg(8'hFF, 8'hEF);
    halt_try(1'b1, 1);
    halt_try(1'b0, 0);
  endtask

  task sc_codes;
    for (int i = 0; i < 4; i++)
    begin
      b0 = {3'h5, i[1:0], 3'h7};
      // Doubler only on the 2-4 MHz band; long delay kept for the resonator
      b1 = {2'h2, i[1:0], i[2:0], i != 1};
      load(b0, b1);
      check_cfg(b0, b1);
    end
  endtask

  task sc_lock;
    int n;
    load(8'h5E, 8'h52);
    check_cfg(8'h5E, 8'h52);
    halt_try(1'b1, 0);
    // Main oscillator never reports ready, so only the backup clock can finish
    exit_try(1'b0, 256 + 2);
    axw(`OBCD_ADDR_CTRL, 32'h1, `OBCD_RESP_OKAY);
    axw(`OBCD_ADDR_CTRL, 32'h3, `OBCD_RESP_OKAY);
    n = 0;
    while (flash_mass_erase !== 1'b1 && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 20) timeout;
    chk(flash_mass_erase, 1'b1);
    axr(`OBCD_ADDR_OPT0, 32'h5E, `OBCD_RESP_OKAY, 1'b1);
    axr(`OBCD_ADDR_STAT, 32'h7, `OBCD_RESP_OKAY, 1'b1);
    n = 0;
    while (flash_mass_erase !== 1'b0 && n < 100)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 100) timeout;
    repeat (3) @(posedge aclk);
    axr(`OBCD_ADDR_OPT0, 32'hFF, `OBCD_RESP_OKAY, 1'b1);
    axr(`OBCD_ADDR_OPT1, 32'hFF, `OBCD_RESP_OKAY, 1'b1);
    rst;
    check_cfg(8'hFF, 8'hFF);
  endtask

  initial
  begin
    {aresetn, por_n, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {halt_entry, wdg_running, halt_exit_req, main_osc_ready} = 4'h0;
    mismatches = 0;
    checked = 0;
    @(posedge aclk);
    por_n <= 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sc_blank;
    sc_codes;
    sc_lock;
    print_verdict;
  end
endmodule // tb_option_byte_config_decoder
